// ===== rtl/scm_clock_select.sv
// sample clock source selection, rate programming and clock output
// Operation
// RL1: source select register holds and returns mode
// RL2: read-only mask shows available mode codes
// RL3: code 1 uses quartz one into PLL
// RL4: code 4 uses optional second quartz
// RL5: code 32 feeds external reference into PLL
// RL6: code 64 uses backplane reference, variant only
// RL7: code 8 clocks from DC pin, gaps allowed
// RL8: code 1024 clocks from AC pin directly
// RL9: software writes wanted sample rate in hertz
// RL10: rate read returns nearest achievable rate
// RL11: clock output enable one drives, zero tristates
// RL12: read-only frequency of synthesized output clock
// RL13: clock output usable with every source
// RL14: external reference divided and multiplied by PLL
// RL15: backplane supplies 100 MHz differential reference
// RL16: master feeds one clock to eight cards
// RL17: shared clock from quartz one or reference
// RL18: unavailable mode code write is ignored
`timescale 1ns/1ns
`default_nettype none
`include "scm_defs.svh"

module scm_clock_select #(
  parameter bit HAS_QUARTZ2 = 1'b1,
  parameter bit HAS_BACKPLANE = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire scm_pkg::scm_reg_req_t reg_req,
  output var scm_pkg::scm_reg_rsp_t reg_rsp,
  // external clock pins
  input wire logic dc_clock_input,
  input wire logic ac_clock_input,
  input wire logic ext_ref_input,
  input wire logic backplane_ref_input,
  // clock distribution control
  input wire logic sync_master,
  // clock outputs
  output logic sample_clock,
  output logic clock_out,
  output logic clock_out_oe,
  output logic [`SCM_FANOUT-1:0] sync_clock_out
);
  import scm_pkg::*;

  localparam logic [31:0] AVAIL_MASK = 32'h0000_0429 |
    (HAS_QUARTZ2 ? 32'h0000_0004 : 32'h0000_0000) |
    (HAS_BACKPLANE ? 32'h0000_0040 : 32'h0000_0000);

  scm_state_t q;
  scm_state_t next_q;
  logic [3:0] pin_raw;
  logic [3:0] pin_lvl;
  logic [63:0] rate_round;
  logic [63:0] nco_prod;
  logic ref_lvl;
  logic ref_edge;
  logic pll_run;
  logic src_clk;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // granularity of the synthesized rate for a source
  function automatic logic [5:0] mode_step(input scm_mode_t m);
    case (m)
      mode_second_oscillator: mode_step = `SCM_STEP_QUARTZ2;
      mode_external_reference_pll: mode_step = `SCM_STEP_EXTREF;
      mode_backplane_reference_pll: mode_step = `SCM_STEP_BACKPLANE;
      default: mode_step = `SCM_STEP_QUARTZ1;
    endcase
  endfunction

  // true for the sources that go through the PLL
  function automatic logic is_pll_mode(input scm_mode_t m);
    case (m)
      mode_internal_quartz_pll, mode_second_oscillator,
      mode_external_reference_pll, mode_backplane_reference_pll: is_pll_mode = 1'b1;
      default: is_pll_mode = 1'b0;
    endcase
  endfunction

  // nearest rate on the source grid, clamped to the range
  function automatic logic [63:0] round_rate(input logic [63:0] req, input logic [5:0] sh);
    logic [63:0] step;
    logic [63:0] r;
    step = 64'h0000_0000_0000_0001 << sh;
    r = (req + (step >> 1)) & ~(step - 64'h0000_0000_0000_0001);
    if (r < `SCM_RATE_MIN) begin
      r = `SCM_RATE_MIN;
    end else if (r > `SCM_RATE_MAX) begin
      r = `SCM_RATE_MAX;
    end
    round_rate = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  assign pin_raw = {backplane_ref_input, ext_ref_input, ac_clock_input, dc_clock_input};

  generate
    for (genvar i = 0; i < 4; i++) begin : g_pin
      scm_pin_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pin_in(pin_raw[i]),
        .level(pin_lvl[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // source selection

  // reference for the PLL: external pin or backplane
  assign ref_lvl = (q.mode == mode_backplane_reference_pll) ? pin_lvl[3] : pin_lvl[2]; // see RL6
  assign ref_edge = ref_lvl & ~q.ref_prev;

  // quartz sources always run; reference sources stop when the reference is lost
  always_comb begin
    case (q.mode)
      mode_internal_quartz_pll: pll_run = 1'b1; // see RL3
      mode_second_oscillator: pll_run = HAS_QUARTZ2; // see RL4
      mode_external_reference_pll: pll_run = (q.ref_idle != `SCM_REF_TIMEOUT); // see RL5
      mode_backplane_reference_pll: pll_run = (q.ref_idle != `SCM_REF_TIMEOUT); // see RL6
      default: pll_run = 1'b0;
    endcase
  end

  // sample clock source: PLL phase or a direct state clock pin
  always_comb begin
    case (q.mode)
      mode_direct_dc_state_clock: src_clk = pin_lvl[0]; // see RL7
      mode_direct_ac_state_clock: src_clk = pin_lvl[1]; // see RL8
      default: src_clk = q.phase[31];
    endcase
  end

  // nearest achievable rate and phase step for it
  assign rate_round = round_rate(q.rate_req, mode_step(q.mode)); // see RL10
  assign nco_prod = q.rate_act * `SCM_NCO_K; // see RL14

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_q = q;
    next_q.rsp.ack = 1'b0;
    next_q.ref_prev = ref_lvl;
    next_q.rate_act = rate_round;
    // reference watchdog, counts clocks since the last reference edge
    if (ref_edge) begin
      next_q.ref_idle = 8'h00;
    end else if (q.ref_idle != `SCM_REF_TIMEOUT) begin
      next_q.ref_idle = q.ref_idle + 8'h01;
    end
    // phase accumulator standing in for the PLL output
    if (pll_run) begin
      next_q.phase = q.phase + nco_prod[39:8]; // see RL14
    end
    // direct modes follow the pin as it comes, gaps included
    next_q.sclk = src_clk; // see RL7
    // distribution only from quartz one or the external reference
    if (sync_master && (q.mode == mode_internal_quartz_pll ||
        q.mode == mode_external_reference_pll)) begin
      next_q.sync_out = {`SCM_FANOUT{src_clk}}; // see RL16 and RL17
    end else begin
      next_q.sync_out = '0;
    end
    // register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        `SCM_REG_SAMPLE_RATE: next_q.rate_req = reg_req.wdata; // see RL9
        `SCM_REG_CLKOUT_EN: next_q.clkout_en = reg_req.wdata[0]; // see RL11
        `SCM_REG_SOURCE_SEL: begin
          // only single known codes that this card carries are taken
          if ((reg_req.wdata[63:32] == 32'h0000_0000) &&
              ((reg_req.wdata[31:0] & ~AVAIL_MASK) == 32'h0000_0000) &&
              $onehot(reg_req.wdata[31:0])) begin
            next_q.mode = scm_mode_t'(reg_req.wdata[10:0]); // see RL1 and RL18
          end
        end
        default: begin
        end
      endcase
    end
    // register reads, answered one clock later
    if (reg_req.rd) begin
      next_q.rsp.ack = 1'b1;
      case (reg_req.addr)
        `SCM_REG_SAMPLE_RATE: next_q.rsp.rdata = q.rate_act; // see RL10
        `SCM_REG_CLKOUT_EN: next_q.rsp.rdata = {63'h0, q.clkout_en};
        `SCM_REG_CLKOUT_FREQ: begin
          // only a synthesized clock has a known frequency
          next_q.rsp.rdata = is_pll_mode(q.mode) ? q.rate_act : 64'h0; // see RL12
        end
        `SCM_REG_SOURCE_SEL: next_q.rsp.rdata = {53'h0, q.mode}; // see RL1
        `SCM_REG_SOURCE_MASK: next_q.rsp.rdata = {32'h0, AVAIL_MASK}; // see RL2
        default: next_q.rsp.rdata = 64'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.mode <= mode_internal_quartz_pll;
      q.rate_req <= `SCM_RATE_RST;
      q.rate_act <= `SCM_RATE_RST;
      q.clkout_en <= `SCM_CLKOUT_EN_RST;
      q.ref_idle <= `SCM_REF_TIMEOUT;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rsp = q.rsp;
  assign sample_clock = q.sclk;
  // output pin carries the sample clock whatever the source
  assign clock_out = q.sclk; // see RL13
  assign clock_out_oe = q.clkout_en; // see RL11
  assign sync_clock_out = q.sync_out;

endmodule

`default_nettype wire

// ===== shared/scm_defs.svh
// register numbers, reset values and timing counts for the sample clock selector
`ifndef SCM_DEFS_SVH
`define SCM_DEFS_SVH

// register numbers as seen on the register port
`define SCM_REG_SAMPLE_RATE 16'h4e20
`define SCM_REG_CLKOUT_EN 16'h4e8e
`define SCM_REG_CLKOUT_FREQ 16'h4e8f
`define SCM_REG_SOURCE_SEL 16'h4ee8
`define SCM_REG_SOURCE_MASK 16'h4ee9

// reset values
`define SCM_RATE_RST 64'h0000_0000_0098_9680
`define SCM_CLKOUT_EN_RST 1'b0

// achievable internal rate range in hertz
`define SCM_RATE_MIN 64'h0000_0000_0000_03e8
`define SCM_RATE_MAX 64'h0000_0000_02fa_f080

// rate granularity per source, as a power of two of hertz
`define SCM_STEP_QUARTZ1 6'h00
`define SCM_STEP_QUARTZ2 6'h0a
`define SCM_STEP_BACKPLANE 6'h0a
`define SCM_STEP_EXTREF 6'h10

// phase step = rate * 2^40 / 100 MHz, then >> 8
`define SCM_NCO_K 64'h0000_0000_0000_2af3

// reference counted as lost after this many clocks without an edge
`define SCM_REF_TIMEOUT 8'h40

// number of cards fed by the clock distribution
`define SCM_FANOUT 8

`endif

// ===== shared/scm_pkg.sv
// types shared by the sample clock selector
package scm_pkg;

  // clock source codes as written to the source select register
  typedef enum logic [10:0] {
    mode_internal_quartz_pll = 11'b000_0000_0001,
    mode_second_oscillator = 11'b000_0000_0100,
    mode_direct_dc_state_clock = 11'b000_0000_1000,
    mode_external_reference_pll = 11'b000_0010_0000,
    mode_backplane_reference_pll = 11'b000_0100_0000,
    mode_direct_ac_state_clock = 11'b100_0000_0000
  } scm_mode_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [63:0] wdata;
  } scm_reg_req_t;

  // register port answer
  typedef struct packed {
    logic ack;
    logic [63:0] rdata;
  } scm_reg_rsp_t;

  // pin synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } scm_sync_t;

  // selector state
  typedef struct packed {
    scm_mode_t mode;
    logic [63:0] rate_req;
    logic [63:0] rate_act;
    logic clkout_en;
    logic [31:0] phase;
    logic ref_prev;
    logic [7:0] ref_idle;
    logic sclk;
    logic [7:0] sync_out;
    scm_reg_rsp_t rsp;
  } scm_state_t;

endpackage

// ===== rtl/scm_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module scm_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and filtered level
  input wire logic pin_in,
  output logic level
);
  import scm_pkg::*;

  scm_sync_t q;
  scm_sync_t next_q;

  // first stage feeds only the second; level moves once stages two and three agree
  always_comb begin
    next_q = q;
    next_q.s1 = pin_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    if (q.s2 == q.s3) begin
      next_q.level = q.s3;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign level = q.level;

endmodule

`default_nettype wire

// ===== dv/scm_clock_select_properties.sv
// port assertions for the sample clock selector
`timescale 1ns/1ns
`default_nettype none
`include "scm_defs.svh"

module scm_clock_select_properties #(
  parameter bit HAS_QUARTZ2 = 1'b1,
  parameter bit HAS_BACKPLANE = 1'b0
) (
  // clock, reset and register port
  input wire logic clk,
  input wire logic rst,
  input wire scm_pkg::scm_reg_req_t reg_req,
  input wire scm_pkg::scm_reg_rsp_t reg_rsp,
  // clock distribution and output
  input wire logic sync_master,
  input wire logic clock_out_oe,
  input wire logic [`SCM_FANOUT-1:0] sync_clock_out
);
  // mask expected from the fitted sources
  localparam logic [63:0] MASK = 64'h429 | (HAS_QUARTZ2 ? 64'h4 : 64'h0)
    | (HAS_BACKPLANE ? 64'h40 : 64'h0);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // register access steps
  sequence s_rd(a);
    reg_req.rd && reg_req.addr == a;
  endsequence
  sequence s_wr(a, d);
    reg_req.wr && reg_req.addr == a && reg_req.wdata == d;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  read_ack_a: assert property (reg_req.rd |=> reg_rsp.ack)
    else $error("read not answered");
  ack_cause_a: assert property (reg_rsp.ack |-> $past(reg_req.rd))
    else $error("answer without read");
  unmapped_zero_a: assert property (s_rd(16'h1234) |=> reg_rsp.rdata == 64'h0)
    else $error("unmapped read not zero");
  mask_value_a: assert property (s_rd(`SCM_REG_SOURCE_MASK) |=> reg_rsp.rdata == MASK)
    else $error("mask mismatch");
  rate_range_a: assert property (s_rd(`SCM_REG_SAMPLE_RATE) |=>
    reg_rsp.rdata >= `SCM_RATE_MIN && reg_rsp.rdata <= `SCM_RATE_MAX)
    else $error("rate out of range");
  oe_on_a: assert property (s_wr(`SCM_REG_CLKOUT_EN, 64'h1) |=> clock_out_oe)
    else $error("output not driven");
  oe_off_a: assert property (s_wr(`SCM_REG_CLKOUT_EN, 64'h0) |=> !clock_out_oe)
    else $error("output not tristated");
  oe_hold_a: assert property (!(reg_req.wr && reg_req.addr == `SCM_REG_CLKOUT_EN) |=>
    $stable(clock_out_oe)) else $error("enable changed unasked");
  fanout_idle_a: assert property ((!sync_master) [*2] |-> sync_clock_out == '0)
    else $error("fanout active off master");
  fanout_same_a: assert property (sync_clock_out == '0 || sync_clock_out == '1)
    else $error("fanout copies differ");
endmodule

bind scm_clock_select scm_clock_select_properties #(
  .HAS_QUARTZ2(HAS_QUARTZ2),
  .HAS_BACKPLANE(HAS_BACKPLANE)
) u_scm_clock_select_properties (
  .clk(clk), .rst(rst), .reg_req(reg_req), .reg_rsp(reg_rsp), .sync_master(sync_master),
  .clock_out_oe(clock_out_oe), .sync_clock_out(sync_clock_out)
);
`default_nettype wire

// ===== dv/scm_ext_clocks.sv
// external clock sources feeding the selector pins
`timescale 1ns/1ns
`default_nettype none

module scm_ext_clocks (
  // source run controls
  input wire logic run_dc,
  input wire logic run_ac,
  input wire logic run_ref,
  input wire logic run_bp,
  // clock pins
  output logic dc_clock_input,
  output logic ac_clock_input,
  output logic ext_ref_input,
  output logic backplane_ref_input
);
  // state clocks rest low while stopped, so gaps reach the pins
  initial begin
    dc_clock_input = 1'b0;
    forever #23 dc_clock_input = run_dc & ~dc_clock_input;
  end
  initial begin
    ac_clock_input = 1'b0;
    forever #17 ac_clock_input = run_ac & ~ac_clock_input;
  end
  // steady references, backplane at 100 MHz off the bench phase
  initial begin
    backplane_ref_input = 1'b0;
    #2;
    forever #5 backplane_ref_input = run_bp & ~backplane_ref_input;
  end
  initial begin
    ext_ref_input = 1'b0;
    forever #51 ext_ref_input = run_ref & ~ext_ref_input;
  end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the sample clock selector
`timescale 1ns/1ns
`default_nettype none
`include "scm_defs.svh"

module tb_top;
  import scm_pkg::*;
  typedef struct {logic [63:0] m, r, q, f;} scm_tb_row_t;
  logic clk, rst, sync_master, run_dc, run_ac, dc, ac, er, bp;
  logic sample_clock, clock_out, clock_out_oe;
  logic [`SCM_FANOUT-1:0] sync_clock_out;
  scm_reg_req_t req;
  scm_reg_rsp_t rsp;
  int failures, check_count, ns, ny;
  // mode, rate written, rate read back, output frequency read back
  scm_tb_row_t rows[7] = '{
    '{64'h1, 64'h03b9_aca0, 64'h02fa_f080, 64'h02fa_f080},
    '{64'h1, 64'h3e7, 64'h3e8, 64'h3e8},
    '{64'h4, 64'h0012_d687, 64'h0012_d800, 64'h0012_d800},
    '{64'h40, 64'h0012_d687, 64'h0012_d800, 64'h0012_d800},
    '{64'h20, 64'h0098_9680, 64'h0099_0000, 64'h0099_0000},
    '{64'h8, 64'h0012_d687, 64'h0012_d687, 64'h0},
    '{64'h400, 64'h1388, 64'h1388, 64'h0}};

  scm_clock_select #(.HAS_QUARTZ2(1'b1), .HAS_BACKPLANE(1'b1)) u_scm_clock_select (
    .clk(clk), .rst(rst), .reg_req(req), .reg_rsp(rsp), .dc_clock_input(dc),
    .ac_clock_input(ac), .ext_ref_input(er), .backplane_ref_input(bp),
    .sync_master(sync_master), .sample_clock(sample_clock), .clock_out(clock_out),
    .clock_out_oe(clock_out_oe), .sync_clock_out(sync_clock_out));
  scm_ext_clocks u_scm_ext_clocks (.run_dc(run_dc), .run_ac(run_ac), .run_ref(1'b1),
    .run_bp(1'b1), .dc_clock_input(dc), .ac_clock_input(ac), .ext_ref_input(er),
    .backplane_ref_input(bp));

  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [63:0] d);
    @(posedge clk) #1 req = '{1'b1, 1'b0, a, d};
    @(posedge clk) #1 req.wr = 1'b0;
  endtask
  // one-cycle read strobe, answer stands for the cycle after the taking edge
  task automatic rd(input logic [15:0] a, input logic [63:0] e);
    @(posedge clk) #1 req = '{1'b0, 1'b1, a, 64'h0};
    @(posedge clk) #1 req.rd = 1'b0;
    chk(64'(rsp.ack), 64'h1);
    chk(rsp.rdata, e);
  endtask
  // count changes of the sample clock and of one fanout copy
  task automatic tog(output int s, output int y);
    logic ps, py;
    s = 0;
    y = 0;
    ps = sample_clock;
    py = sync_clock_out[0];
    repeat (200) begin
      @(posedge clk) #1;
      s += int'(sample_clock !== ps);
      y += int'(sync_clock_out[0] !== py);
      ps = sample_clock;
      py = sync_clock_out[0];
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    failures++;
    end_sim();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    req = '0;
    sync_master = 1'b0;
    run_dc = 1'b0;
    run_ac = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    rd(`SCM_REG_SAMPLE_RATE, `SCM_RATE_RST);
    rd(`SCM_REG_SOURCE_SEL, 64'h1);
    rd(`SCM_REG_CLKOUT_EN, 64'h0);
    rd(`SCM_REG_SOURCE_MASK, 64'h46d);
    foreach (rows[i]) begin
      wr(`SCM_REG_SOURCE_SEL, rows[i].m);
      wr(`SCM_REG_SAMPLE_RATE, rows[i].r);
      rd(`SCM_REG_SOURCE_SEL, rows[i].m);
      rd(`SCM_REG_SAMPLE_RATE, rows[i].q);
      rd(`SCM_REG_CLKOUT_FREQ, rows[i].f);
    end
    // refused codes and read-only places
    wr(`SCM_REG_SOURCE_SEL, 64'h3);
    wr(`SCM_REG_SOURCE_SEL, 64'h2);
    wr(`SCM_REG_SOURCE_SEL, 64'h0000_0001_0000_0001);
    wr(`SCM_REG_SOURCE_MASK, 64'h0);
    wr(`SCM_REG_CLKOUT_FREQ, 64'h1234);
    rd(`SCM_REG_SOURCE_SEL, 64'h400);
    rd(`SCM_REG_SOURCE_MASK, 64'h46d);
    rd(`SCM_REG_CLKOUT_FREQ, 64'h0);
    rd(16'h1234, 64'h0);
    // direct state clocks, with a gap on the DC input
    run_ac = 1'b1;
    tog(ns, ny);
    chk(64'(ns > 0), 64'h1);
    wr(`SCM_REG_SOURCE_SEL, 64'h8);
    run_dc = 1'b1;
    wr(`SCM_REG_CLKOUT_EN, 64'h1);
    chk(64'(clock_out_oe), 64'h1);
    tog(ns, ny);
    chk(64'(ns > 0), 64'h1);
    chk(64'(clock_out), 64'(sample_clock));
    run_dc = 1'b0;
    repeat (10) @(posedge clk);
    tog(ns, ny);
    chk(64'(ns), 64'h0);
    wr(`SCM_REG_CLKOUT_EN, 64'h0);
    chk(64'(clock_out_oe), 64'h0);
    // distributed clock from quartz one and reference, then none from second quartz
    sync_master = 1'b1;
    wr(`SCM_REG_SAMPLE_RATE, 64'h017d_7840);
    wr(`SCM_REG_SOURCE_SEL, 64'h1);
    tog(ns, ny);
    chk(64'(ns > 0 && ny > 0), 64'h1);
    wr(`SCM_REG_SOURCE_SEL, 64'h20);
    tog(ns, ny);
    chk(64'(ns > 0 && ny > 0), 64'h1);
    wr(`SCM_REG_SOURCE_SEL, 64'h4);
    repeat (3) @(posedge clk);
    #1 chk(64'(sync_clock_out), 64'h0);
    // reset in mid-run brings back the defaults
    wr(`SCM_REG_CLKOUT_EN, 64'h1);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk(64'(clock_out_oe), 64'h0);
    rd(`SCM_REG_SOURCE_SEL, 64'h1);
    rd(`SCM_REG_SAMPLE_RATE, `SCM_RATE_RST);
    rd(`SCM_REG_CLKOUT_EN, 64'h0);
    end_sim();
  end
endmodule
`default_nettype wire
